// ==== vectored_interrupt_controller_tb.sv ====
// self-checking bench for controller and cpu end joined by the link
`timescale 1ns/1ps
`include "vic_defines.svh"
module vectored_interrupt_controller_tb;
  import vic_pkg::*;
  logic        core_clk_i = 0;
  logic        resetn_i = 0;
  logic        wr = 0;
  logic        rd = 0;
  logic        return_from_interrupt_instr = 0;
  logic [31:0] fix = 0, fab = 0, wd = 0, rdata, d, w, m, e;
  logic [15:0] d0 = 0, d1 = 0, pc = 0, br_a, res_a;
  logic [7:0]  addr = 0;
  logic        br, res;
  logic [3:0]  dep;
  int          n_mismatch = 0, n_compared = 0, seed = 31531;
  int          prio [32];       // model priority per vector
  logic [15:0] isa [32];        // model routine address per vector
  vic_link_if link ();
  wire [2:0]   ev = {res, br, link.irq_request};
  vic_controller i_vic_controller (.core_clk_i(core_clk_i),
    .resetn_i(resetn_i), .fixed_irq_i(fix), .dma_term_group_zero_i(d0),
    .dma_term_group_one_i(d1), .fabric_irq_i(fab), .reg_addr_i(addr),
    .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .link(link));
  vic_cpu_end i_vic_cpu_end (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .pc_i(pc), .return_from_interrupt_instr_i(return_from_interrupt_instr), .branch_o(br), .branch_addr_o(br_a),
    .resume_o(res), .resume_addr_o(res_a), .isr_depth_o(dep), .link(link));
  vic_assertions i_vic_assertions (.core_clk_i(core_clk_i),
    .resetn_i(resetn_i), .irq_request(link.irq_request),
    .irq_vector(link.irq_vector), .isr_address(link.isr_address),
    .cpu_irq_acknowledge(link.cpu_irq_acknowledge),
    .isr_complete(link.isr_complete));
  always #20 core_clk_i = ~core_clk_i;
  // ****
  // tasks
  // ****
  task chk(input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x) begin
      n_mismatch++;
      $display("ERROR %0t seen %h expected %h", $time, s, x);
    end
  endtask : chk
  task results;
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results
  // one-cycle write strobe
  task wt(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk_i);
    addr <= a;
    wd <= v;
    wr <= 1'b1;
    @(posedge core_clk_i);
    wr <= 1'b0;
  endtask : wt
  // read data is looked at only in the cycle after the strobe
  task rt(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk_i);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rt
  // bounded wait on request, branch or resume
  task wait_ev(input int i);
    int k;
    k = 0;
    #1;  // let this edge's register updates land before looking
    while (ev[i] !== 1'b1) begin
      if (k == 200) begin
        n_mismatch++;
        results();
      end
      @(posedge core_clk_i);
      #1 k++;
    end
  endtask : wait_ev
  // rising edge on one source line of vector v, then all lines drop
  task pulse(input int s, input int v);
    @(posedge core_clk_i);
    if (s == 0) fix[v] <= 1'b1;
    else if (s == 1 && v < 16) d0[v] <= 1'b1;
    else if (s == 1) d1[v-16] <= 1'b1;
    else fab[v] <= 1'b1;
    repeat (5) @(posedge core_clk_i);
    fix <= '0;
    fab <= '0;
    d0 <= '0;
    d1 <= '0;
  endtask : pulse
  // full service of vector v: request, branch, return
  task serve(input int v);
    logic [15:0] p;
    p = $random(seed);
    @(posedge core_clk_i);
    pc <= p;
    wait_ev(0);
    chk(link.irq_vector, v);
    chk(link.isr_address, isa[v]);
    wait_ev(1);
    chk(br_a, isa[v]);
    chk(dep, 1);
    @(posedge core_clk_i);
    return_from_interrupt_instr <= 1'b1;
    @(posedge core_clk_i);
    return_from_interrupt_instr <= 1'b0;
    wait_ev(2);
    chk(res_a, p);
    // after completion the level and depth are back to idle
    rt(`REG_ACTIVE, d);
    chk(d & 32'h0000_0FFF, `IDLE_LEVEL);
  endtask : serve
  // ****
  // main sequence
  // ****
  initial begin
    int v, s, k;
    repeat (12) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    rt(`REG_ENABLE, d);
    chk(d, `ENABLE_RST);
    rt(8'h44, d);
    chk(d, 0);
    // only the selected source of a vector may pending_flag it
    for (s = 0; s < 3; s++) begin
      v = $unsigned($random(seed)) % 32;
      wt(`REG_SRC_LO, {16{s[1:0]}});
      wt(`REG_SRC_HI, {16{s[1:0]}});
      pulse((s + 1) % 3, v);
      pulse((s + 2) % 3, v);
      rt(`REG_PENDING, d);
      chk(d, 0);
      pulse(s, v);
      rt(`REG_PENDING, d);
      chk(d, 32'h1 << v);
      rt(`REG_POSTED, d);
      chk(d, 32'h1 << v);
      wt(`REG_CLR_PENDING_FLAG, 32'h1 << v);
      rt(`REG_PENDING, d);
      chk(d, 0);
    end
    // software raised sets served in model priority order
    wt(`REG_SRC_LO, 32'hFFFF_FFFF);
    wt(`REG_SRC_HI, 32'hFFFF_FFFF);
    for (k = 0; k < 2; k++) begin
      for (v = 0; v < 32; v++) begin
        prio[v] = $unsigned($random(seed)) % 8;
        isa[v] = $random(seed);
        wt(`REG_ISR_BASE + 8'(4 * v), {16'h0000, isa[v]});
      end
      for (v = 0; v < 4; v++) begin
        for (s = 0; s < 8; s++) w[4*s +: 4] = 4'(prio[8*v+s]);
        wt(`REG_PRIO_BASE + 8'(4 * v), w);
      end
      m = $random(seed);
      e = $random(seed);
      wt(`REG_ENABLE, 0);
      wt(`REG_SET_PENDING_FLAG, m);
      wt(`REG_ENABLE, e);
      while ((m & e) != 0) begin
        s = -1;
        for (v = 0; v < 32; v++)
          if (m[v] && e[v] && (s < 0 || prio[v] < prio[s])) s = v;
        m[s] = 1'b0;
        serve(s);
      end
      rt(`REG_PENDING, d);
      chk(d, m);
      chk(link.irq_request, 0);
      wt(`REG_CLR_PENDING_FLAG, 32'hFFFF_FFFF);
    end
    results();
  end
endmodule : vectored_interrupt_controller_tb

// ==== vic_assertions.sv ====
// handshake checker for the link between controller and cpu end
`timescale 1ns/1ps
`include "vic_defines.svh"
module vic_assertions (
  input wire logic                   core_clk_i,
  input wire logic                   resetn_i,
  input wire logic                   irq_request,
  input wire logic [4:0]             irq_vector,
  input wire logic [`ISR_ADDR_W-1:0] isr_address,
  input wire logic                   cpu_irq_acknowledge,
  input wire logic                   isr_complete
);
  // ****
  // one clock domain, so one default clock and reset
  // ****
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);
  // request seen, acknowledged next edge, then dropped
  sequence s_hand;
    ##1 (irq_request && cpu_irq_acknowledge) ##1 !irq_request;
  endsequence
  // acknowledge stands seven cycles, then falls
  sequence s_ack_hold;
    cpu_irq_acknowledge [*7] ##1 !cpu_irq_acknowledge;
  endsequence
  AST_IRQ_HAND:
    assert property ($rose(irq_request) |-> s_hand)
    else $error("request not answered in two cycles");
  AST_ACK_HOLD:
    assert property ($rose(cpu_irq_acknowledge) |-> s_ack_hold)
    else $error("acknowledge not held seven cycles");
  AST_ACK_CAUSE:
    assert property ($rose(cpu_irq_acknowledge) |-> $past(irq_request))
    else $error("acknowledge without request");
  AST_VEC_HOLD:
    assert property (!$rose(irq_request) |->
      ($stable(irq_vector) && $stable(isr_address)))
    else $error("vector or address moved outside a new request");
  AST_NO_REQ_ACK:
    assert property (cpu_irq_acknowledge |-> !$rose(irq_request))
    else $error("new request while acknowledge high");
  AST_EVAL_GAP:
    assert property ($fell(cpu_irq_acknowledge) |-> !irq_request [*3])
    else $error("request sooner than evaluation allows");
  AST_DONE_PULSE:
    assert property (isr_complete |=> !isr_complete)
    else $error("completion longer than one cycle");
  AST_REQ_DROP:
    assert property ($fell(irq_request) |-> $past(cpu_irq_acknowledge))
    else $error("request dropped without acknowledge");
endmodule : vic_assertions

// ==== vic_controller.sv ====
// thirty-two vector interrupt controller with software register port
`timescale 1ns/1ps
`include "vic_defines.svh"
module vic_controller
  import vic_pkg::*;
#(
  parameter int NEST_DEPTH = `NEST_LEVELS
) (
  input  wire logic                   core_clk_i,
  input  wire logic                   resetn_i,
  input  wire logic [31:0]            fixed_irq_i,
  input  wire logic [15:0]            dma_term_group_zero_i,
  input  wire logic [15:0]            dma_term_group_one_i,
  input  wire logic [31:0]            fabric_irq_i,
  input  wire logic [`REG_ADDR_W-1:0] reg_addr_i,
  input  wire logic [31:0]            reg_wdata_i,
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  output logic [31:0]                 reg_rdata_o,
  vic_link_if.controller              link
);
  // nesting stack indices are three bits wide
  if (NEST_DEPTH < 1 || NEST_DEPTH > 8) begin : g_bad_depth
    $error("vic_controller: NEST_DEPTH must be 1 to 8");
  end
  // ****************************************
  // storage
  // ****************************************
  logic [31:0]            enable_r;     // per vector enable
  logic [63:0]            src_sel_r;    // two bits per vector
  logic [2:0]             prio_r [32];  // 0 is most urgent
  logic [`ISR_ADDR_W-1:0] isr_r [32];   // routine address per vector
  logic [31:0]            sync1_r;      // first synchroniser stage
  logic [31:0]            sync2_r;      // second synchroniser stage
  logic [31:0]            prev_r;       // for edge detection
  logic [31:0]            pending_r;    // pending_flag per vector
  logic [31:0]            posted_r;     // posted_flag per vector
  logic [2:0]             stack_r [NEST_DEPTH];  // active levels
  logic [3:0]             depth_r;      // nesting depth
  ctl_state_type          state_r;      // handshake state
  logic [1:0]             cnt_r;        // evaluation clocks left
  logic [4:0]             vec_r;        // vector under service
  logic [4:0]             irq_vec_r;    // vector shown to the cpu
  logic                   irq_r;        // request to cpu
  logic [`ISR_ADDR_W-1:0] addr_r;       // presented routine address
  logic [31:0]            rdata_r;      // read data, one cycle late
  logic [31:0] raw_src;                 // selected line per vector
  logic [31:0] eligible;                // may be presented now
  logic [31:0] prio_word [4];           // priority read images
  logic        win_found;
  logic [4:0]  win_vec;
  logic [2:0]  win_prio;
  // dma lines laid out so that bit n feeds vector n
  wire [31:0] dma_lines = {dma_term_group_one_i,
                           dma_term_group_zero_i};
  // level of the innermost active routine, or idle
  wire [3:0] top_idx   = depth_r - 4'h1;
  wire [3:0] cur_level = (depth_r == 4'h0) ? `IDLE_LEVEL
                         : {1'b0, stack_r[top_idx[2:0]]};
  // ****************************************
  // register decode
  // ****************************************
  wire wr_enable = reg_wr_i && (reg_addr_i == `REG_ENABLE);
  wire wr_src_lo = reg_wr_i && (reg_addr_i == `REG_SRC_LO);
  wire wr_src_hi = reg_wr_i && (reg_addr_i == `REG_SRC_HI);
  wire wr_set    = reg_wr_i && (reg_addr_i == `REG_SET_PENDING_FLAG);
  wire wr_clr    = reg_wr_i && (reg_addr_i == `REG_CLR_PENDING_FLAG);
  wire wr_isr    = reg_wr_i && reg_addr_i[7];
  wire [31:0] sw_set = wr_set ? reg_wdata_i : 32'h0000_0000;
  wire [31:0] sw_clr = wr_clr ? reg_wdata_i : 32'h0000_0000;
  // hardware clears follow the acknowledge, pending first
  wire [31:0] vec_hot  = 32'h0000_0001 << vec_r;
  wire [31:0] hw_pclr  = (state_r == CS_CLR_PENDING_FLAG) ? vec_hot : '0;
  wire [31:0] hw_qclr  = (state_r == CS_CLR_POSTED_FLAG) ? vec_hot : '0;
  wire [31:0] src_rise = sync2_r & ~prev_r;
  // ****************************************
  // per vector logic
  // ****************************************
  for (genvar v = 0; v < 32; v++) begin : g_vec
    wire [1:0] sel = src_sel_r[2*v +: 2];
    // fixed lines 4..12 are the port units, one each
    assign raw_src[v] = (sel == SRC_FIXED)  ? fixed_irq_i[v]
                      : (sel == SRC_DMA)    ? dma_lines[v]
                      : (sel == SRC_FABRIC) ? fabric_irq_i[v]
                      : 1'b0;
    // disabled or not more urgent than the active level: held back
    assign eligible[v] = posted_r[v] & enable_r[v]
                       & ({1'b0, prio_r[v]} < cur_level);
    assign prio_word[v/8][4*(v%8) +: 4] = {1'b0, prio_r[v]};
    // priority and routine address writes for this vector
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        prio_r[v] <= 3'h0;
        isr_r[v]  <= `ISR_ADDR_RST;
      end else begin
        if (reg_wr_i && reg_addr_i == 8'(`REG_PRIO_BASE + 4*(v/8))) begin
          prio_r[v] <= reg_wdata_i[4*(v%8) +: 3];
        end
        if (wr_isr && reg_addr_i[6:2] == 5'(v)) begin
          isr_r[v] <= reg_wdata_i[`ISR_ADDR_W-1:0];
        end
      end
    end
  end
  // ****************************************
  // arbitration: scan down so ties go low
  // ****************************************
  always_comb begin
    win_found = 1'b0;
    win_vec   = 5'h00;
    win_prio  = 3'h7;
    for (int i = 31; i >= 0; i--) begin
      if (eligible[i] && (!win_found || prio_r[i] <= win_prio)) begin
        win_found = 1'b1;
        win_vec   = 5'(i);
        win_prio  = prio_r[i];
      end
    end
  end
  // software control registers, no hardware writer
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      enable_r  <= `ENABLE_RST;
      src_sel_r <= `SRC_RST;
    end else begin
      if (wr_enable) enable_r <= reg_wdata_i;
      if (wr_src_lo) src_sel_r[31:0]  <= reg_wdata_i;
      if (wr_src_hi) src_sel_r[63:32] <= reg_wdata_i;
    end
  end
  // ****************************************
  // synchroniser, pending and posted flags
  // ****************************************
  // a new event wins over any clear in the same cycle
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_r   <= '0;
      sync2_r   <= '0;
      prev_r    <= '0;
      pending_r <= '0;
      posted_r  <= '0;
    end else begin
      sync1_r   <= raw_src;
      sync2_r   <= sync1_r;
      prev_r    <= sync2_r;
      pending_r <= (pending_r & ~(sw_clr | hw_pclr))
                 | src_rise | sw_set;
      posted_r  <= (posted_r & ~(sw_clr | hw_qclr))
                 | (pending_r & ~sw_clr);
    end
  end
  // ****************************************
  // handshake sequence
  // ****************************************
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= CS_IDLE;
      cnt_r   <= 2'h0;
      vec_r   <= 5'h00;
      irq_vec_r <= 5'h00;
      irq_r   <= 1'b0;
      addr_r  <= `ISR_ADDR_RST;
    end else begin
      case (state_r)
        CS_IDLE: begin
          if (win_found && depth_r < 4'(NEST_DEPTH)) begin
            state_r <= CS_EVAL;
            vec_r   <= win_vec;
            cnt_r   <= 2'(`EVAL_CLOCKS - 1);
          end
        end
        CS_EVAL: begin
          // winner withdrawn by software: give up quietly
          if (!eligible[vec_r]) begin
            state_r <= CS_IDLE;
          end else if (cnt_r == 2'h0) begin
            state_r <= CS_REQ;
            irq_r   <= 1'b1;
            addr_r  <= isr_r[vec_r];
            irq_vec_r <= vec_r;
          end else begin
            cnt_r <= cnt_r - 2'h1;
          end
        end
        CS_REQ: begin
          if (link.cpu_irq_acknowledge) begin
            irq_r   <= 1'b0;
            state_r <= CS_CLR_PENDING_FLAG;
          end
        end
        CS_CLR_PENDING_FLAG: state_r <= CS_CLR_POSTED_FLAG;
        CS_CLR_POSTED_FLAG: state_r <= CS_WAIT_ACK;
        CS_WAIT_ACK: begin
          // no new request until the cpu lets go
          if (!link.cpu_irq_acknowledge) state_r <= CS_IDLE;
        end
        default: state_r <= CS_IDLE;
      endcase
    end
  end
  // active status stack: push on acknowledge, pop on completion
  wire push = (state_r == CS_REQ) && link.cpu_irq_acknowledge;
  wire pop  = link.isr_complete && (depth_r != 4'h0);
  wire [3:0] push_idx = pop ? top_idx : depth_r;
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      depth_r <= 4'h0;
    end else begin
      if (push) stack_r[push_idx[2:0]] <= prio_r[vec_r];
      if (push && !pop) depth_r <= depth_r + 4'h1;
      else if (pop && !push) depth_r <= top_idx;
    end
  end
  // ****************************************
  // register read, data one cycle late
  // ****************************************
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;                        // unmapped reads zero
    case (reg_addr_i)
      `REG_ENABLE:              rd_mux = enable_r;
      `REG_SRC_LO:              rd_mux = src_sel_r[31:0];
      `REG_SRC_HI:              rd_mux = src_sel_r[63:32];
      `REG_PRIO_BASE:           rd_mux = prio_word[0];
      `REG_PRIO_BASE + 8'h04:   rd_mux = prio_word[1];
      `REG_PRIO_BASE + 8'h08:   rd_mux = prio_word[2];
      `REG_PRIO_BASE + 8'h0C:   rd_mux = prio_word[3];
      `REG_PENDING:             rd_mux = pending_r;
      `REG_POSTED:              rd_mux = posted_r;
      `REG_ACTIVE: begin
        rd_mux[3:0]                  = cur_level;
        rd_mux[`ACT_DEPTH_LSB +: 4]  = depth_r;
        rd_mux[`ACT_BUSY_BIT]        = (state_r != CS_IDLE);
        rd_mux[`ACT_VEC_LSB +: 5]    = vec_r;
      end
      default: begin
        if (reg_addr_i[7]) begin
          rd_mux[`ISR_ADDR_W-1:0] = isr_r[reg_addr_i[6:2]];
        end
      end
    endcase
  end
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) rdata_r <= 32'h0000_0000;
    else           rdata_r <= reg_rd_i ? rd_mux : 32'h0000_0000;
  end
  // outputs straight from flip-flops; the vector moves only with a request
  assign reg_rdata_o      = rdata_r;
  assign link.irq_request = irq_r;
  assign link.irq_vector  = irq_vec_r;
  assign link.isr_address = addr_r;
endmodule : vic_controller

// ==== vic_cpu_end.sv ====
// cpu side of the interrupt handshake, with a return address stack
`timescale 1ns/1ps
`include "vic_defines.svh"
module vic_cpu_end
  import vic_pkg::*;
#(
  parameter int NEST_DEPTH = `NEST_LEVELS
) (
  input  wire logic                   core_clk_i,
  input  wire logic                   resetn_i,
  input  wire logic [`ISR_ADDR_W-1:0] pc_i,
  input  wire logic                   return_from_interrupt_instr_i,
  output logic                        branch_o,
  output logic [`ISR_ADDR_W-1:0]      branch_addr_o,
  output logic                        resume_o,
  output logic [`ISR_ADDR_W-1:0]      resume_addr_o,
  output logic [3:0]                  isr_depth_o,
  vic_link_if.cpu                     link
);

  // ****************************************
  // parameter check
  // ****************************************
  if (NEST_DEPTH < 1 || NEST_DEPTH > 8) begin : g_bad_depth
    $error("vic_cpu_end: NEST_DEPTH must be 1 to 8");
  end

  cpu_state_type          state_r;     // handshake state
  logic [2:0]             hold_r;      // cycles left with ack high
  logic                   ack_r;       // acknowledge to controller
  logic                   done_r;      // completion pulse
  logic                   branch_r;    // branch pulse
  logic                   resume_r;    // resume pulse
  logic [`ISR_ADDR_W-1:0] target_r;    // fetched routine address
  logic [`ISR_ADDR_W-1:0] ret_addr_r;  // popped return address
  logic [`ISR_ADDR_W-1:0] stack_r [NEST_DEPTH];
  logic [3:0]             depth_r;     // saved frames

  // ****************************************
  // decode
  // ****************************************
  wire take = (state_r == PS_RUN) && link.irq_request
              && (depth_r < 4'(NEST_DEPTH));
  // a return while acking is held off: the routine has not begun yet
  wire ret  = (state_r == PS_RUN) && return_from_interrupt_instr_i && (depth_r != 4'h0) && !take;
  wire [3:0] top = depth_r - 4'h1;

  // ****************************************
  // handshake sequence
  // ****************************************
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r  <= PS_RUN;
      hold_r   <= 3'h0;
      ack_r    <= 1'b0;
      target_r <= `ISR_ADDR_RST;
    end else begin
      case (state_r)
        PS_RUN: begin
          if (take) begin
            state_r <= PS_ACK;
            ack_r   <= 1'b1;
            hold_r  <= 3'(`ACK_HOLD_CYCLES - 1);
          end
        end
        PS_ACK: begin
          // address is read once ack stands
          if (hold_r == 3'(`ACK_HOLD_CYCLES - 1)) begin
            target_r <= link.isr_address;
          end
          if (hold_r == 3'h0) begin
            ack_r   <= 1'b0;
            state_r <= PS_DONE;
          end else begin
            hold_r <= hold_r - 3'h1;
          end
        end
        PS_DONE: state_r <= PS_RUN;                // branch taken
        default: state_r <= PS_RUN;
      endcase
    end
  end

  // ****************************************
  // return stack and pulses
  // ****************************************
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      depth_r    <= 4'h0;
      branch_r   <= 1'b0;
      resume_r   <= 1'b0;
      done_r     <= 1'b0;
      ret_addr_r <= `ISR_ADDR_RST;
    end else begin
      branch_r <= (state_r == PS_ACK) && (hold_r == 3'h0);
      resume_r <= ret;
      done_r   <= ret;
      if (take) begin
        stack_r[depth_r[2:0]] <= pc_i;
        depth_r <= depth_r + 4'h1;
      end else if (ret) begin
        ret_addr_r <= stack_r[top[2:0]];
        depth_r    <= top;
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign link.cpu_irq_acknowledge = ack_r;
  assign link.isr_complete        = done_r;
  assign branch_o                 = branch_r;
  assign branch_addr_o            = target_r;
  assign resume_o                 = resume_r;
  assign resume_addr_o            = ret_addr_r;
  assign isr_depth_o              = depth_r;

endmodule : vic_cpu_end

// ==== vic_defines.svh ====
// constants for the vectored interrupt controller and its cpu end
`ifndef VIC_DEFINES_SVH
`define VIC_DEFINES_SVH

// ****************************************
// sizes
// ****************************************
`define VEC_COUNT        32
`define NEST_LEVELS      8
`define ISR_ADDR_W       16
`define REG_ADDR_W       8
`define IDLE_LEVEL       4'h8

// ****************************************
// timing counts, in core clocks
// ****************************************
`define EVAL_CLOCKS      3
`define ACK_HOLD_CYCLES  7

// ****************************************
// register byte offsets
// ****************************************
`define REG_ENABLE       8'h00
`define REG_SRC_LO       8'h04
`define REG_SRC_HI       8'h08
`define REG_PRIO_BASE    8'h0C
`define REG_SET_PENDING_FLAG     8'h1C
`define REG_CLR_PENDING_FLAG     8'h20
`define REG_PENDING      8'h24
`define REG_POSTED       8'h28
`define REG_ACTIVE       8'h2C
`define REG_ISR_BASE     8'h80

// ****************************************
// reset values and field positions
// ****************************************
`define ENABLE_RST       32'h0000_0000
`define SRC_RST          64'h0000_0000_0000_0000
`define ISR_ADDR_RST     16'h0000
`define ACT_DEPTH_LSB    8
`define ACT_BUSY_BIT     16
`define ACT_VEC_LSB      24
`define PORT_UNIT_FIRST  4
`define PORT_UNIT_LAST   12

`endif

// ==== vic_link_if.sv ====
// link between the interrupt controller and the cpu core
`timescale 1ns/1ps
`include "vic_defines.svh"
interface vic_link_if;
  logic                     irq_request;          // request to the cpu
  logic [4:0]               irq_vector;           // winning vector number
  logic [`ISR_ADDR_W-1:0]   isr_address;          // routine address
  logic                     cpu_irq_acknowledge;  // cpu took the request
  logic                     isr_complete;         // routine finished

  modport controller (
    output irq_request,
    output irq_vector,
    output isr_address,
    input  cpu_irq_acknowledge,
    input  isr_complete
  );

  modport cpu (
    input  irq_request,
    input  irq_vector,
    input  isr_address,
    output cpu_irq_acknowledge,
    output isr_complete
  );
endinterface : vic_link_if

// ==== vic_pkg.sv ====
// types shared by the interrupt controller and its cpu end
package vic_pkg;

  // ****************************************
  // source selector per vector
  // ****************************************
  typedef enum logic [1:0] {
    SRC_FIXED  = 2'h0,  // dedicated peripheral line
    SRC_DMA    = 2'h1,  // dma terminal output line
    SRC_FABRIC = 2'h2,  // logic fabric line
    SRC_OFF    = 2'h3   // no source
  } src_sel_type;

  // ****************************************
  // controller sequence
  // ****************************************
  typedef enum logic [5:0] {
    CS_IDLE     = 6'b00_0001,
    CS_EVAL     = 6'b00_0010,
    CS_REQ      = 6'b00_0100,
    CS_CLR_PENDING_FLAG = 6'b00_1000,
    CS_CLR_POSTED_FLAG = 6'b01_0000,
    CS_WAIT_ACK = 6'b10_0000
  } ctl_state_type;

  // ****************************************
  // cpu end sequence
  // ****************************************
  typedef enum logic [2:0] {
    PS_RUN  = 3'b001,
    PS_ACK  = 3'b010,
    PS_DONE = 3'b100
  } cpu_state_type;

endpackage : vic_pkg
